/* rtl/hsbl_pkg.sv */
// constants, register map and pin codes of the host and serial boot loader
// Overview of operation
// [RULE_01] mode 0101 muxed host, 0110 plain host
// [RULE_02] host port configured, ready pin goes low
// [RULE_03] host may instead wait 200 cycles
// [RULE_04] host boot loads directly, no boot table
// [RULE_05] host image kept within words 0100h-3FFFh
// [RULE_06] mailbox high word 0060h, low 0061h
// [RULE_07] poll flag byte, branch when non-zero
// [RULE_08] host writes low word, then high word
// [RULE_09] high word: flag 15-8, address 7-0
// [RULE_10] host word address is half byte address
// [RULE_11] warm boot rewrites only the mailbox
// [RULE_12] host boot: no reconfiguration, no delays
// [RULE_13] receiver: one phase, one word, right-justified
// [RULE_14] sender supplies clock, one sync per word
// [RULE_15] serial ready pin low after about 200 cycles
// [RULE_16] receive clock at most one eighth CPU clock
// [RULE_17] ready high while copying or delaying
// [RULE_18] sender paces words to avoid overflow
// [RULE_19] ready rises about 50 cycles after word
// [RULE_20] ready rises once per completed object
// [RULE_21] unpolled sender leaves 120 cycles per word
// [RULE_22] table end: ready high, branch to entry
// [RULE_23] mode 1110 16-bit serial, 1111 8-bit
// [RULE_24] mode pins sampled once after reset
// [RULE_25] ready held high until interface configured
package hsbl_pkg;
  // boot mode select codes, pins in order 3,2,1,0
  localparam logic [3:0] MODE_HOST_MUX    = 4'h5;
  localparam logic [3:0] MODE_HOST_NONMUX = 4'h6;
  localparam logic [3:0] MODE_SER16       = 4'he;
  localparam logic [3:0] MODE_SER8        = 4'hf;
  // receiver configuration fields
  localparam logic       RX_PHASE_SINGLE  = 1'h0;
  localparam logic [6:0] RX_FRAME_ONE     = 7'h00;
  localparam logic [1:0] RX_WDLEN_8       = 2'h0;
  localparam logic [1:0] RX_WDLEN_16      = 2'h1;
  localparam logic [1:0] RX_JUST_RIGHT    = 2'h0;
  localparam logic [1:0] RX_DATDLY_ONE    = 2'h1;
  // timing in CPU cycles
  localparam int CFG_CYCLES     = 200;
  localparam int LATENCY_CYCLES = 50;
  localparam int READY_CYCLES   = 120;
  localparam int SAMPLE_CYCLES  = 3;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL    = 10'h000;
  localparam logic [9:0] IDX_STATUS  = 10'h001;
  localparam logic [9:0] IDX_OBJECT  = 10'h002;
  localparam logic [9:0] IDX_DELAY   = 10'h003;
  localparam logic [9:0] IDX_ENTRY   = 10'h004;
  localparam logic [9:0] IDX_RXCFG   = 10'h005;
  localparam logic [9:0] IDX_MBX_HI  = 10'h060;
  localparam logic [9:0] IDX_MBX_LO  = 10'h061;
  // control bits
  localparam int CTRL_OBJ32 = 0;
  localparam int CTRL_END   = 1;
  // status bits
  localparam int ST_READY   = 0;
  localparam int ST_HOST    = 1;
  localparam int ST_SERIAL  = 2;
  localparam int ST_WIDE    = 3;
  localparam int ST_RUN     = 4;
  localparam int ST_OVF     = 5;
  localparam int ST_DLYPEND = 6;
  localparam int ST_MODE_LO = 8;
endpackage : hsbl_pkg

/* rtl/hsbl_sync.sv */
// two-stage synchroniser for pins entering the mclk domain
`timescale 1ns/1ps
`default_nettype none
module hsbl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  // asynchronous inputs and synchronised copies
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : hsbl_sync
`default_nettype wire

/* rtl/hsbl_ser_rx.sv */
// serial receiver: one phase, one word per frame, right-justified, msb first
`timescale 1ns/1ps
`default_nettype none
module hsbl_ser_rx #(
  parameter int DATA_DELAY = 1
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // synchronised link signals
  input  wire logic        rx_clk_i,
  input  wire logic        rx_fs_i,
  input  wire logic        rx_dat_i,
  // configuration
  input  wire logic        enable_i,
  input  wire logic        wide_i,
  // received word
  output logic             word_valid_o,
  output logic      [15:0] word_o
);
  logic        clk_prev_q;
  logic        active_q;
  logic [4:0]  bits_left_q;
  logic [15:0] shift_q;
  logic        fall;

  // data and sync are taken on the falling receive clock edge
  assign fall = clk_prev_q & ~rx_clk_i;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= rx_clk_i;
    end
  end

  // the first bit comes DATA_DELAY edges after sync; extra early bits shift out of the top
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_q    <= 1'b0;
      bits_left_q <= '0;
      shift_q     <= '0;
    end else if (!enable_i) begin
      active_q <= 1'b0;
    end else if (fall && rx_fs_i) begin
      active_q    <= 1'b1;
      bits_left_q <= 5'((wide_i ? 16 : 8) + DATA_DELAY - 1); // [RULE_13]
    end else if (fall && active_q) begin
      shift_q     <= {shift_q[14:0], rx_dat_i};
      bits_left_q <= bits_left_q - 5'h01;
      if (bits_left_q == 5'h01) begin
        active_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_valid_o <= 1'b0;
      word_o       <= '0;
    end else begin
      word_valid_o <= fall && active_q && !rx_fs_i && bits_left_q == 5'h01;
      if (fall && active_q && !rx_fs_i && bits_left_q == 5'h01) begin
        word_o <= wide_i ? {shift_q[14:0], rx_dat_i} : {8'h00, shift_q[6:0], rx_dat_i}; // [RULE_13]
      end
    end
  end
endmodule : hsbl_ser_rx
`default_nettype wire

/* rtl/hsbl_top.sv */
// boot loader core: mode capture, host mailbox, serial object pacing, apb registers
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module hsbl_top (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // boot pins
  input  wire logic [3:0]  boot_mode_select_pins_i,
  output logic             ready_handshake_pin_o,
  output logic             ready_handshake_pin_oe_o,
  // serial link
  input  wire logic        serial_rx_clock_i,
  input  wire logic        serial_rx_frame_sync_i,
  input  wire logic        serial_rx_data_i,
  // host port configuration
  output logic             host_port_en_o,
  output logic             host_port_mux_o,
  // object stream to memory
  output logic             obj_valid_o,
  output logic      [31:0] obj_data_o,
  // branch to application
  output logic             branch_o,
  output logic      [23:0] entry_addr_o
);
  typedef enum {
    SM_SAMPLE, SM_CONFIG, SM_HOST_WAIT, SM_SER_READY, SM_SER_LATENCY,
    SM_SER_BUSY, SM_DELAY, SM_RUN, SM_FAIL, SM_IDLE
  } hsbl_state_type;

  hsbl_state_type state_q;
  hsbl_state_type state_d;

  logic [3:0]  pins_sync;
  logic [2:0]  link_sync;
  logic [3:0]  mode_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] mbx_hi_q;
  logic [15:0] mbx_lo_q;
  logic [23:0] entry_q;
  logic [15:0] delay_q;
  logic        delay_req_q;
  logic        end_req_q;
  logic        obj32_q;
  logic        ovf_q;
  logic [31:0] obj_q;
  logic [2:0]  words_q;
  logic        word_valid;
  logic [15:0] word;
  logic        host_mode;
  logic        ser_mode;
  logic        wide;
  logic        apb_wr;
  logic        apb_setup;
  logic [9:0]  idx;
  logic        obj_done;
  logic        delay_start;

  function automatic logic idx_mapped(input logic [9:0] i);
    idx_mapped = i == hsbl_pkg::IDX_CTRL || i == hsbl_pkg::IDX_STATUS || i == hsbl_pkg::IDX_OBJECT ||
                 i == hsbl_pkg::IDX_DELAY || i == hsbl_pkg::IDX_ENTRY || i == hsbl_pkg::IDX_RXCFG ||
                 i == hsbl_pkg::IDX_MBX_HI || i == hsbl_pkg::IDX_MBX_LO;
  endfunction : idx_mapped

  // words making up one object: 8-bit link 2 or 4, 16-bit link 1 or 2
  function automatic logic [2:0] words_per_obj(input logic is_wide, input logic is_obj32);
    case ({is_wide, is_obj32})
      2'h0:    words_per_obj = 3'h2;
      2'h1:    words_per_obj = 3'h4;
      2'h2:    words_per_obj = 3'h1;
      default: words_per_obj = 3'h2;
    endcase
  endfunction : words_per_obj

  hsbl_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (boot_mode_select_pins_i),
    .sync_o    (pins_sync)
  );

  hsbl_sync #(
    .WIDTH (3)
  ) u_link_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({serial_rx_clock_i, serial_rx_frame_sync_i, serial_rx_data_i}),
    .sync_o    (link_sync)
  );

  hsbl_ser_rx #(
    .DATA_DELAY (int'(hsbl_pkg::RX_DATDLY_ONE))
  ) u_rx (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .rx_clk_i     (link_sync[2]),
    .rx_fs_i      (link_sync[1]),
    .rx_dat_i     (link_sync[0]),
    .enable_i     (ser_mode && state_q != hsbl_state_type'(SM_CONFIG) && state_q != SM_RUN),
    .wide_i       (wide),
    .word_valid_o (word_valid),
    .word_o       (word)
  );

  assign host_mode   = mode_q == hsbl_pkg::MODE_HOST_MUX || mode_q == hsbl_pkg::MODE_HOST_NONMUX;   // [RULE_01]
  assign ser_mode    = mode_q == hsbl_pkg::MODE_SER16 || mode_q == hsbl_pkg::MODE_SER8;             // [RULE_23]
  assign wide        = mode_q == hsbl_pkg::MODE_SER16;                                              // [RULE_23]
  assign apb_setup   = psel_i && !penable_i;
  assign apb_wr      = psel_i && penable_i && pwrite_i;
  assign idx         = paddr_i[11:2];
  assign obj_done    = word_valid && state_q == SM_SER_READY && words_q + 3'h1 == words_per_obj(wide, obj32_q);
  assign delay_start = state_q == SM_SER_BUSY && cnt_q == 16'h0001 && delay_req_q;

  // mode pins are read once, after they have settled through the synchroniser
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= 4'h0;
    end else if (state_q == SM_SAMPLE && cnt_q == 16'(hsbl_pkg::SAMPLE_CYCLES)) begin
      mode_q <= pins_sync; // [RULE_24]
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 16'h0001;
    case (state_q)
      SM_SAMPLE: begin
        if (cnt_q == 16'(hsbl_pkg::SAMPLE_CYCLES)) begin
          cnt_d = 16'h0000;
          if (pins_sync == hsbl_pkg::MODE_HOST_MUX || pins_sync == hsbl_pkg::MODE_HOST_NONMUX ||
              pins_sync == hsbl_pkg::MODE_SER16 || pins_sync == hsbl_pkg::MODE_SER8) begin
            state_d = SM_CONFIG;
          end else begin
            state_d = SM_IDLE;
          end
        end
      end
      SM_CONFIG: begin
        // the port is configured before the pin may drop, so the far side sees not ready until then
        if (cnt_q == 16'(hsbl_pkg::CFG_CYCLES - hsbl_pkg::SAMPLE_CYCLES - 2)) begin // [RULE_25]
          state_d = host_mode ? SM_HOST_WAIT : SM_SER_READY;                          // [RULE_02] [RULE_15]
        end
      end
      SM_HOST_WAIT: begin
        cnt_d = cnt_q;
        // no boot table here: the host fills memory, the loader only polls the flag byte
        if (mbx_hi_q[15:8] != 8'h00) begin // [RULE_07] [RULE_04]
          state_d = SM_RUN;
        end
      end
      SM_SER_READY: begin
        cnt_d = 16'h0000;
        if (obj_done) begin
          state_d = SM_SER_LATENCY; // [RULE_20]
        end else if (end_req_q) begin
          state_d = SM_RUN;         // [RULE_22]
        end
      end
      SM_SER_LATENCY: begin
        if (word_valid) begin
          state_d = SM_FAIL;
        end else if (cnt_q == 16'(hsbl_pkg::LATENCY_CYCLES - 1)) begin // [RULE_19]
          state_d = SM_SER_BUSY;
          cnt_d   = 16'(hsbl_pkg::READY_CYCLES - hsbl_pkg::LATENCY_CYCLES);
        end
      end
      SM_SER_BUSY: begin
        cnt_d = cnt_q - 16'h0001;
        if (word_valid) begin
          state_d = SM_FAIL; // [RULE_17]
        end else if (cnt_q == 16'h0001) begin
          if (delay_req_q && delay_q != 16'h0000) begin
            state_d = SM_DELAY;
            cnt_d   = delay_q;
          end else begin
            state_d = SM_SER_READY;
          end
        end
      end
      SM_DELAY: begin
        cnt_d = cnt_q - 16'h0001;
        if (word_valid) begin
          state_d = SM_FAIL;
        end else if (cnt_q == 16'h0001) begin
          state_d = SM_SER_READY; // [RULE_17]
        end
      end
      SM_RUN: begin
        cnt_d = cnt_q;
      end
      SM_FAIL: begin
        cnt_d = cnt_q;
      end
      SM_IDLE: begin
        cnt_d = cnt_q;
      end
      default: begin
        state_d = SM_FAIL;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= SM_SAMPLE;
      cnt_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // pin is high in reset and low while the port can take a transfer and during the latency after an object
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ready_handshake_pin_o    <= 1'b1; // [RULE_25]
      ready_handshake_pin_oe_o <= 1'b1;
    end else begin
      ready_handshake_pin_o    <= !(state_d == SM_HOST_WAIT || state_d == SM_SER_READY ||
                                    state_d == SM_SER_LATENCY); // [RULE_17] [RULE_22]
      ready_handshake_pin_oe_o <= state_d != SM_IDLE;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_port_en_o  <= 1'b0;
      host_port_mux_o <= 1'b0;
    end else begin
      host_port_en_o  <= host_mode && state_q != SM_SAMPLE;                 // [RULE_01]
      host_port_mux_o <= mode_q == hsbl_pkg::MODE_HOST_MUX;                // [RULE_01]
    end
  end

  // object assembly: words arrive msb first and shift in from the bottom
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      obj_q   <= 32'h0000_0000;
      words_q <= 3'h0;
    end else if (word_valid && state_q == SM_SER_READY) begin
      obj_q   <= wide ? {obj_q[15:0], word} : {obj_q[23:0], word[7:0]};
      words_q <= obj_done ? 3'h0 : words_q + 3'h1;
    end
  end

  // the copy to memory happens as the pin goes high
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      obj_valid_o <= 1'b0;
      obj_data_o  <= 32'h0000_0000;
    end else begin
      obj_valid_o <= state_q == SM_SER_LATENCY && state_d == SM_SER_BUSY;
      if (state_q == SM_SER_LATENCY && state_d == SM_SER_BUSY) begin
        obj_data_o <= obj_q;
      end
    end
  end

  // a word landing while the loader is still busy is lost, so the boot stops
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovf_q <= 1'b0;
    end else if (state_d == SM_FAIL && state_q != SM_FAIL) begin
      ovf_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      branch_o     <= 1'b0;
      entry_addr_o <= 24'h00_0000;
    end else begin
      branch_o <= state_q != SM_RUN && state_d == SM_RUN;
      if (state_q != SM_RUN && state_d == SM_RUN) begin
        entry_addr_o <= host_mode ? {mbx_hi_q[7:0], mbx_lo_q} : entry_q; // [RULE_06] [RULE_22]
      end
    end
  end

  // mailbox words, written by the host port path
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mbx_hi_q <= 16'h0000;
      mbx_lo_q <= 16'h0000;
    end else if (apb_wr) begin
      if (idx == hsbl_pkg::IDX_MBX_HI) begin
        mbx_hi_q <= pwdata_i[15:0]; // [RULE_06]
      end
      if (idx == hsbl_pkg::IDX_MBX_LO) begin
        mbx_lo_q <= pwdata_i[15:0]; // [RULE_06]
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      obj32_q <= 1'b0;
      entry_q <= 24'h00_0000;
    end else if (apb_wr) begin
      if (idx == hsbl_pkg::IDX_CTRL) begin
        obj32_q <= pwdata_i[hsbl_pkg::CTRL_OBJ32];
      end
      if (idx == hsbl_pkg::IDX_ENTRY) begin
        entry_q <= pwdata_i[23:0];
      end
    end
  end

  // delay and end requests only exist with a boot table, so host boot ignores them
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      delay_q     <= 16'h0000;
      delay_req_q <= 1'b0;
      end_req_q   <= 1'b0;
    end else begin
      if (apb_wr && idx == hsbl_pkg::IDX_DELAY && ser_mode) begin // [RULE_12]
        delay_q     <= pwdata_i[15:0];
        delay_req_q <= 1'b1;
      end else if (delay_start) begin
        delay_req_q <= 1'b0;
      end
      if (apb_wr && idx == hsbl_pkg::IDX_CTRL && ser_mode && pwdata_i[hsbl_pkg::CTRL_END]) begin // [RULE_12]
        end_req_q <= 1'b1;
      end
    end
  end

  // read data and error are prepared in the setup phase; the access phase never waits
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      pslverr_o <= !idx_mapped(idx);
      prdata_o  <= 32'h0000_0000;
      case (idx)
        hsbl_pkg::IDX_CTRL:   prdata_o <= {30'h0000_0000, end_req_q, obj32_q};
        hsbl_pkg::IDX_STATUS: begin
          prdata_o[hsbl_pkg::ST_READY]   <= !ready_handshake_pin_o;
          prdata_o[hsbl_pkg::ST_HOST]    <= host_mode;
          prdata_o[hsbl_pkg::ST_SERIAL]  <= ser_mode;
          prdata_o[hsbl_pkg::ST_WIDE]    <= wide;
          prdata_o[hsbl_pkg::ST_RUN]     <= state_q == SM_RUN;
          prdata_o[hsbl_pkg::ST_OVF]     <= ovf_q;
          prdata_o[hsbl_pkg::ST_DLYPEND] <= delay_req_q;
          prdata_o[hsbl_pkg::ST_MODE_LO +: 4] <= mode_q;
        end
        hsbl_pkg::IDX_OBJECT: prdata_o <= obj_data_o;
        hsbl_pkg::IDX_DELAY:  prdata_o <= {16'h0000, delay_q};
        hsbl_pkg::IDX_ENTRY:  prdata_o <= {8'h00, entry_q};
        hsbl_pkg::IDX_RXCFG:  prdata_o <= {18'h0_0000, hsbl_pkg::RX_DATDLY_ONE, hsbl_pkg::RX_JUST_RIGHT,
                                           hsbl_pkg::RX_FRAME_ONE, hsbl_pkg::RX_PHASE_SINGLE,
                                           wide ? hsbl_pkg::RX_WDLEN_16 : hsbl_pkg::RX_WDLEN_8}; // [RULE_13]
        hsbl_pkg::IDX_MBX_HI: prdata_o <= {16'h0000, mbx_hi_q};
        hsbl_pkg::IDX_MBX_LO: prdata_o <= {16'h0000, mbx_lo_q};
        default:              prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign pready_o = 1'b1;
endmodule : hsbl_top
`default_nettype wire

/* sim/hsbl_properties.sv */
// concurrent checks on the boot loader top ports
`timescale 1ns/1ps
`default_nettype none
module hsbl_properties (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  // watched outputs
  input wire logic        ready_handshake_pin_o,
  input wire logic        ready_handshake_pin_oe_o,
  input wire logic        host_port_en_o,
  input wire logic        host_port_mux_o,
  input wire logic        obj_valid_o,
  input wire logic        branch_o,
  input wire logic [23:0] entry_addr_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_rst_not_ready: assert property ($fell(sys_rst_i) |-> ready_handshake_pin_o [*8])
    else $error("ready pin low right after reset");
  a_obj_pin_rise: assert property (obj_valid_o |-> $rose(ready_handshake_pin_o))
    else $error("object not marked by a ready pin rise");
  a_copy_busy: assert property (obj_valid_o |=> ready_handshake_pin_o [*8])
    else $error("ready pin low while copying");
  a_branch_pin: assert property (branch_o |-> ready_handshake_pin_o)
    else $error("branch with ready pin low");
  a_branch_pulse: assert property (branch_o |=> !branch_o)
    else $error("branch pulse too long");
  a_entry_held: assert property (branch_o |=> $stable(entry_addr_o) [*4])
    else $error("entry moved after branch");
  a_mux_needs_en: assert property (host_port_mux_o |-> host_port_en_o)
    else $error("mux set without host port");
  a_mode_once: assert property (!$fell(host_port_en_o) && !$fell(host_port_mux_o))
    else $error("captured mode changed");
  a_ready_driven: assert property (!ready_handshake_pin_o |-> ready_handshake_pin_oe_o)
    else $error("ready low while not driven");
  a_host_no_obj: assert property (host_port_en_o |-> !obj_valid_o)
    else $error("object in host boot");
endmodule : hsbl_properties
bind hsbl_top hsbl_properties u_props (.*);
`default_nettype wire

/* sim/hsbl_sender.sv */
// serial boot source: frames msb first on an 80 ns link clock
`timescale 1ns/1ps
`default_nettype none
module hsbl_sender (
  // link pins
  output logic clk_o,
  output logic fs_o,
  output logic dat_o
);
  initial begin
    clk_o = 1'b0;
    fs_o  = 1'b0;
    dat_o = 1'b0;
  end
  // clock rests low between frames; a released data line shows the inverse of its last bit
  task automatic send(input logic [15:0] w, input int n);
    for (int i = 0; i <= n; i++) begin
      clk_o = 1'b1;
      fs_o  = (i == 0);
      dat_o = (i == 0) ? ~dat_o : w[n-i];
      #40 clk_o = 1'b0;
      #40;
    end
    fs_o  = 1'b0;
    dat_o = ~dat_o;
  endtask : send
endmodule : hsbl_sender
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the host and serial boot loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("ERROR at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic        mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, obj_data_o;
  logic [3:0]  boot_mode_select_pins_i;
  logic        ready_handshake_pin_o, ready_handshake_pin_oe_o, host_port_en_o, host_port_mux_o;
  logic        serial_rx_clock_i, serial_rx_frame_sync_i, serial_rx_data_i, obj_valid_o, branch_o;
  logic [23:0] entry_addr_o;
  int          errors, checked, nbr;
  hsbl_top DUT (.*);
  hsbl_sender SND (.clk_o(serial_rx_clock_i), .fs_o(serial_rx_frame_sync_i), .dat_o(serial_rx_data_i));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (branch_o === 1'b1) nbr++;
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= {i, 2'h0};
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    if (n >= 16) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, pready_o, 1'b1);
      stop_test();
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask : wr
  function automatic logic pick(input int k);
    return (k == 0) ? ready_handshake_pin_o : (k == 1) ? branch_o : obj_valid_o;
  endfunction : pick
  task automatic wait_for(input int k, input logic v, output int n);
    n = 0;
    while (pick(k) !== v) begin
      @(negedge mclk_i);
      n++;
      if (n > 400) begin
        errors++;
        $display("ERROR at %0t: signal %h never reached %h", $time, k, v);
        stop_test();
      end
    end
  endtask : wait_for
  task automatic do_reset(input logic [3:0] m);
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    boot_mode_select_pins_i <= m;
    repeat (4) @(posedge mclk_i);
    `CHK(ready_handshake_pin_o, 1'b1)
    sys_rst_i <= 1'b0;
  endtask : do_reset
  // sender paces every unit on the ready pin, so no overflow is provoked
  task automatic send_obj(input logic [31:0] v, input logic wide, input logic big, output int n);
    int u;
    int b;
    u = wide ? (big ? 2 : 1) : (big ? 4 : 2);
    b = wide ? 16 : 8;
    for (int j = 0; j < u; j++) begin
      wait_for(0, 1'b0, n);
      SND.send(16'(v >> (b * (u - 1 - j))), b);
      if (j < u - 1) begin
        repeat (130) @(negedge mclk_i);
        `CHK(ready_handshake_pin_o, 1'b0)
      end
    end
    wait_for(2, 1'b1, n);
    `CHK(ready_handshake_pin_o, 1'b1)
  endtask : send_obj
  task automatic t_host(input logic [3:0] m, input logic mux, input logic [23:0] a);
    int          n;
    int          b;
    logic [31:0] r;
    logic        e;
    do_reset(m);
    if (mux) begin
      wait_for(0, 1'b0, n);
      `CHK(n > 150 && n < 260, 1'b1)
    end else begin
      // this host ignores the pin and only counts cycles after release
      repeat (200) @(posedge mclk_i);
      @(negedge mclk_i);
      `CHK(ready_handshake_pin_o, 1'b0)
    end
    `CHK(host_port_en_o, 1'b1)
    `CHK(host_port_mux_o, mux)
    b = nbr;
    wr(hsbl_pkg::IDX_MBX_LO, {16'h0000, a[15:0]});
    wr(hsbl_pkg::IDX_MBX_HI, {24'h00_0000, a[23:16]});
    wr(hsbl_pkg::IDX_DELAY, 32'h0010);
    wr(hsbl_pkg::IDX_CTRL, 32'h0002);
    apb(1'b0, 10'h3ff, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    repeat (20) @(negedge mclk_i);
    `CHK(nbr - b, 0)
    `CHK(ready_handshake_pin_o, 1'b0)
    wr(hsbl_pkg::IDX_MBX_HI, {16'h0000, 8'h0a, a[23:16]});
    wait_for(1, 1'b1, n);
    `CHK(n < 4, 1'b1)
    `CHK(entry_addr_o, a)
    $display("host boot mode %h finished", m);
  endtask : t_host
  task automatic t_ser(input logic [3:0] m, input logic wide);
    int          n;
    logic [31:0] r;
    logic        e;
    do_reset(m);
    wait_for(0, 1'b0, n);
    `CHK(n > 150 && n < 260, 1'b1)
    `CHK(host_port_en_o, 1'b0)
    apb(1'b0, hsbl_pkg::IDX_RXCFG, 32'h0, r, e);
    `CHK(r, {18'h0, 2'h1, 10'h0, 1'b0, wide})
    send_obj(32'ha5c3, wide, 1'b0, n);
    `CHK(obj_data_o, 32'h0000a5c3)
    `CHK(n > 40 && n < 60, 1'b1)
    wait_for(0, 1'b0, n);
    `CHK(n > 60 && n < 80, 1'b1)
    wr(hsbl_pkg::IDX_CTRL, 32'h1);
    wr(hsbl_pkg::IDX_DELAY, 32'h0010);
    send_obj(32'h1234abcd, wide, 1'b1, n);
    `CHK(obj_data_o, 32'h1234abcd)
    wr(hsbl_pkg::IDX_ENTRY, 32'habcdef);
    wait_for(0, 1'b0, n);
    `CHK(n > 75 && n < 95, 1'b1)
    wr(hsbl_pkg::IDX_CTRL, 32'h3);
    wait_for(1, 1'b1, n);
    `CHK(entry_addr_o, 24'habcdef)
    `CHK(ready_handshake_pin_o, 1'b1)
    apb(1'b0, hsbl_pkg::IDX_STATUS, 32'h0, r, e);
    `CHK(r, {20'h0_0000, m, 4'h1, wide, 3'h4})
    $display("serial boot mode %h finished", m);
  endtask : t_ser
  task automatic t_bad();
    do_reset(4'h0);
    repeat (300) @(negedge mclk_i);
    `CHK({ready_handshake_pin_o, ready_handshake_pin_oe_o}, 2'h2)
    $display("reserved mode finished");
  endtask : t_bad
  initial begin
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h0;
    pwdata_i = 32'h0;
    boot_mode_select_pins_i = 4'h0;
    errors = 0;
    checked = 0;
    // entry byte 2000h: image loaded at word 1000h
    t_host(hsbl_pkg::MODE_HOST_MUX, 1'b1, 24'h002000);
    t_host(hsbl_pkg::MODE_HOST_NONMUX, 1'b0, 24'h123456);
    t_ser(hsbl_pkg::MODE_SER16, 1'b1);
    t_ser(hsbl_pkg::MODE_SER8, 1'b0);
    t_bad();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
